// ### rtl/acr_pkg.sv
// Constants and types shared by the converter configuration register group.
package acr_pkg;

  localparam int          NUM_CH          = 8;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;

  // Register addresses.
  localparam logic [7:0]  ADDR_AVG_CFG    = 8'h03;
  localparam logic [7:0]  ADDR_MODE_CFG   = 8'h04;
  localparam logic [7:0]  ADDR_FUNC_CFG   = 8'h05;
  localparam logic [7:0]  ADDR_DIR_CFG    = 8'h07;
  localparam logic [7:0]  ADDR_DRIVE_CFG  = 8'h09;
  localparam logic [7:0]  ADDR_LEVEL_VAL  = 8'h0B;
  localparam logic [7:0]  ADDR_INPUT_VAL  = 8'h0D;

  // Reset value of every register in the group.
  localparam logic [7:0]  REG_RESET       = 8'h00;

  // Averaging configuration fields.
  localparam int          AVG_DEPTH_LSB   = 0;
  localparam int          AVG_DEPTH_W     = 3;

  // Operating mode fields.
  localparam int          HALT_ERR_BIT    = 7;
  localparam int          TRIG_LSB        = 5;
  localparam int          TRIG_W          = 2;
  localparam int          OSC_BIT         = 4;
  localparam int          DIV_LSB         = 0;
  localparam int          DIV_W           = 4;

  // Conversion trigger codes; the two upper codes are reserved.
  localparam logic [1:0]  TRIG_HOST       = 2'h0;
  localparam logic [1:0]  TRIG_AUTO       = 2'h1;

  typedef enum logic [0:0] {
    ACR_SEQ_RUN   = 1'b0,
    ACR_SEQ_PAUSE = 1'b1
  } acr_seq_t;

endpackage : acr_pkg

// ### rtl/acr_pin_if.sv
// Carrier for pin configuration passed from the register bank to the pin stage.
`timescale 1ns/10ps
interface acr_pin_if;
  logic [7:0] func;
  logic [7:0] dir;
  logic [7:0] drive;
  logic [7:0] level;
  logic       force_analog;

  modport cfg (output func, output dir, output drive, output level, output force_analog);
  modport pin (input func, input dir, input drive, input level, input force_analog);
endinterface : acr_pin_if

// ### rtl/acr_pin_stage.sv
// Per-channel pin driver: analog or digital role, direction and drive type.
`timescale 1ns/10ps
module acr_pin_stage
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Configuration
  acr_pin_if.pin                 cfg,
  // Pin side
  output logic [NUM_CH-1:0]      pin_out,
  output logic [NUM_CH-1:0]      pin_oe,
  output logic [NUM_CH-1:0]      ch_analog
);

  logic [NUM_CH-1:0] drv_en;

  // A forced state overrides function and direction, yet leaves the stored setup untouched.
  always_comb begin
    drv_en = cfg.func & cfg.dir & {NUM_CH{~cfg.force_analog}};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ch_analog <= '1;
    end else begin
      ch_analog <= cfg.force_analog ? '1 : ~cfg.func;
    end
  end

  // Open-drain lets go of the pin for a high level so the external pull-up sets it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else begin
      pin_oe  <= drv_en & (cfg.drive | ~cfg.level);
      pin_out <= drv_en & cfg.level;
    end
  end

  a_forced_analog: assert property (@(posedge clk) disable iff (!reset_n)
    cfg.force_analog |=> (pin_oe == '0) && (ch_analog == '1))
    else $error("forced analog state still drives a pin");

  a_pin_drive: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg.force_analog |=> pin_oe == $past(cfg.func & cfg.dir & (cfg.drive | ~cfg.level)))
    else $error("pin enable does not match drive configuration");

  a_channel_role: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg.force_analog |=> ch_analog == ~$past(cfg.func))
    else $error("channel role does not follow function bits");

  a_output_level: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_oe & ~$past(cfg.drive)) != '0 |-> (pin_out & pin_oe & ~$past(cfg.drive)) == '0)
    else $error("open-drain output drives a high level");

endmodule : acr_pin_stage

// ### rtl/acr_config_regs.sv
// Configuration register group: averaging, operating mode and channel pin setup.
`timescale 1ns/10ps
module acr_config_regs
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic                          CLOCK,
  input  wire logic                          RESET_N,
  // Register access
  input  wire logic [acr_pkg::ADDR_W-1:0]    REG_ADDR,
  input  wire logic                          REG_WR,
  input  wire logic [acr_pkg::DATA_W-1:0]    REG_WDATA,
  input  wire logic                          REG_RD,
  output logic [acr_pkg::DATA_W-1:0]         REG_RDATA,
  output logic                               REG_RVALID,
  // Device control
  input  wire logic                          SW_RESET,
  input  wire logic                          CHECK_ERROR,
  input  wire logic                          FORCE_ALL_ANALOG,
  // Conversion setup
  output logic [acr_pkg::AVG_DEPTH_W-1:0]    AVG_DEPTH,
  output logic                               TRIG_AUTONOMOUS,
  output logic                               OSC_LOW_POWER,
  output logic [acr_pkg::DIV_W-1:0]          SAMPLE_DIV,
  output logic                               SEQ_ENABLE,
  // Channel pins
  input  wire logic [acr_pkg::NUM_CH-1:0]    PIN_IN,
  output logic [acr_pkg::NUM_CH-1:0]         PIN_OUT,
  output logic [acr_pkg::NUM_CH-1:0]         PIN_OE,
  output logic [acr_pkg::NUM_CH-1:0]         CH_ANALOG
);

  import acr_pkg::*;

  logic [AVG_DEPTH_W-1:0] avg_q;
  logic [DATA_W-1:0]      mode_q;
  logic [NUM_CH-1:0]      func_q;
  logic [NUM_CH-1:0]      dir_q;
  logic [NUM_CH-1:0]      drive_q;
  logic [NUM_CH-1:0]      level_q;
  logic [NUM_CH-1:0]      pin_in_q;
  logic [DATA_W-1:0]      rdata_d;
  logic [ADDR_W-1:0]      rd_addr_q;
  logic                   halt_req;
  acr_seq_t               seq_q;
  acr_seq_t               seq_d;

  acr_pin_if pin_cfg ();

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    wr_hit = REG_WR && (REG_ADDR == a);
  endfunction : wr_hit

  // Only code one starts the internal machine, so the reserved codes behave like host start.
  function automatic logic is_auto(input logic [DATA_W-1:0] m);
    is_auto = (m[TRIG_LSB +: TRIG_W] == TRIG_AUTO);
  endfunction : is_auto

  // Writes to unassigned addresses simply match no register below.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      avg_q <= REG_RESET[AVG_DEPTH_W-1:0];
    end else if (SW_RESET) begin
      avg_q <= REG_RESET[AVG_DEPTH_W-1:0];
    end else if (wr_hit(ADDR_AVG_CFG)) begin
      avg_q <= REG_WDATA[AVG_DEPTH_LSB +: AVG_DEPTH_W];
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= REG_RESET;
    end else if (SW_RESET) begin
      mode_q <= REG_RESET;
    end else if (wr_hit(ADDR_MODE_CFG)) begin
      mode_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      func_q  <= REG_RESET;
      dir_q   <= REG_RESET;
      drive_q <= REG_RESET;
      level_q <= REG_RESET;
    end else if (SW_RESET) begin
      func_q  <= REG_RESET;
      dir_q   <= REG_RESET;
      drive_q <= REG_RESET;
      level_q <= REG_RESET;
    end else begin
      if (wr_hit(ADDR_FUNC_CFG)) begin
        func_q <= REG_WDATA;
      end
      if (wr_hit(ADDR_DIR_CFG)) begin
        dir_q <= REG_WDATA;
      end
      if (wr_hit(ADDR_DRIVE_CFG)) begin
        drive_q <= REG_WDATA;
      end
      if (wr_hit(ADDR_LEVEL_VAL)) begin
        level_q <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_in_q <= '0;
    end else begin
      pin_in_q <= PIN_IN;
    end
  end

  always_comb begin
    case (REG_ADDR)
      ADDR_AVG_CFG:   rdata_d = {{(DATA_W-AVG_DEPTH_W){1'b0}}, avg_q};
      ADDR_MODE_CFG:  rdata_d = mode_q;
      ADDR_FUNC_CFG:  rdata_d = func_q;
      ADDR_DIR_CFG:   rdata_d = dir_q;
      ADDR_DRIVE_CFG: rdata_d = drive_q;
      ADDR_LEVEL_VAL: rdata_d = level_q;
      ADDR_INPUT_VAL: rdata_d = pin_in_q;
      default:        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
      rd_addr_q  <= 8'h00;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
        rd_addr_q <= REG_ADDR;
      end
    end
  end

  // The pause is a mask, not a rewrite, so clearing the error restores the old pin setup.
  always_comb begin
    halt_req = mode_q[HALT_ERR_BIT] && CHECK_ERROR;
    seq_d    = halt_req ? ACR_SEQ_PAUSE : ACR_SEQ_RUN;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq_q <= ACR_SEQ_RUN;
    end else begin
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      SEQ_ENABLE <= 1'b1;
    end else begin
      case (seq_d)
        ACR_SEQ_RUN:   SEQ_ENABLE <= 1'b1;
        ACR_SEQ_PAUSE: SEQ_ENABLE <= 1'b0;
        default:       SEQ_ENABLE <= 1'b1;
      endcase
    end
  end

  // Derived outputs lag the registers by one clock so that each port leaves a flop.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVG_DEPTH       <= '0;
      TRIG_AUTONOMOUS <= 1'b0;
      OSC_LOW_POWER   <= 1'b0;
      SAMPLE_DIV      <= '0;
    end else begin
      AVG_DEPTH       <= avg_q;
      TRIG_AUTONOMOUS <= is_auto(mode_q);
      OSC_LOW_POWER   <= mode_q[OSC_BIT];
      SAMPLE_DIV      <= is_auto(mode_q) ? mode_q[DIV_LSB +: DIV_W] : '0;
    end
  end

  assign pin_cfg.func         = func_q;
  assign pin_cfg.dir          = dir_q;
  assign pin_cfg.drive        = drive_q;
  assign pin_cfg.level        = level_q;
  assign pin_cfg.force_analog = FORCE_ALL_ANALOG || (seq_q == ACR_SEQ_PAUSE);

  acr_pin_stage u_pins (
    .clk       (CLOCK),
    .reset_n   (RESET_N),
    .cfg       (pin_cfg),
    .pin_out   (PIN_OUT),
    .pin_oe    (PIN_OE),
    .ch_analog (CH_ANALOG)
  );

  sequence s_err_halted;
    mode_q[HALT_ERR_BIT] && CHECK_ERROR;
  endsequence

  sequence s_err_cleared;
    (mode_q[HALT_ERR_BIT] && CHECK_ERROR) ##1 !CHECK_ERROR;
  endsequence

  a_depth_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    wr_hit(ADDR_AVG_CFG) && !SW_RESET |-> ##2 AVG_DEPTH == $past(REG_WDATA[2:0], 2))
    else $error("averaging depth does not follow write");

  a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    REG_RVALID && rd_addr_q == ADDR_AVG_CFG |-> REG_RDATA[7:3] == 5'h00)
    else $error("reserved averaging bits read nonzero");

  a_no_halt_run: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !mode_q[HALT_ERR_BIT] |=> SEQ_ENABLE)
    else $error("sequencing paused with halt bit clear");

  a_halt_pause: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    s_err_halted |=> !SEQ_ENABLE ##1 PIN_OE == '0)
    else $error("check error did not pause and force analog");

  a_err_resume: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    s_err_cleared |=> SEQ_ENABLE)
    else $error("sequencing did not resume after error clear");

  a_trig_reserved: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    TRIG_AUTONOMOUS |-> $past(mode_q[6:5]) == 2'h1)
    else $error("autonomous trigger without code one");

  a_osc_choice: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    ##1 OSC_LOW_POWER == $past(mode_q[4]))
    else $error("oscillator choice mismatch");

  a_div_gate: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    SAMPLE_DIV != 4'h0 |-> TRIG_AUTONOMOUS)
    else $error("sample divider active outside autonomous mode");

  a_soft_reset: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    SW_RESET && !REG_RD ##1 REG_RD && !REG_WR && REG_ADDR != ADDR_INPUT_VAL
    |=> REG_RDATA == 8'h00)
    else $error("register not zero after software reset");

  a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    REG_RVALID && rd_addr_q inside {8'h06, 8'h08, 8'h0A} |-> REG_RDATA == 8'h00)
    else $error("unassigned address read nonzero");

  a_input_level: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    REG_RVALID && rd_addr_q == ADDR_INPUT_VAL |-> REG_RDATA == $past(PIN_IN, 2))
    else $error("input level readback mismatch");

endmodule : acr_config_regs

// ### tb/acr_host_model.sv
// Host-side model that drives the register strobes and the checksum error flag.
`timescale 1ns/10ps
module acr_host_model
  import acr_pkg::*;
(
  // Clock
  input  wire logic                      clk,
  // Register access
  output logic [acr_pkg::ADDR_W-1:0]     addr,
  output logic                           wr,
  output logic [acr_pkg::DATA_W-1:0]     wdata,
  output logic                           rd,
  input  wire logic [acr_pkg::DATA_W-1:0] rdata,
  input  wire logic                      rvalid,
  // Error flag
  output logic                           err
);
  import acr_pkg::*;

  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
    err = 1'b0;
  end

  // Idle lines show the inverse of the last value, so a stale address cannot pass.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    ok = rvalid;
    d = rdata;
  endtask : rd_reg

  task automatic set_err(input logic v);
    @(negedge clk);
    err = v;
  endtask : set_err
endmodule : acr_host_model

// ### tb/adc_mode_and_pin_config_regs_bench.sv
// Self-checking bench for the converter configuration register group.
`timescale 1ns/10ps
module adc_mode_and_pin_config_regs_bench;
  import acr_pkg::*;
  logic       clk, rst_n, sw_rst, force_an, wr, rd, rvalid, err, trig, osc, seq;
  logic [7:0] addr, wdata, rdata, ext, pin_in, pin_out, pin_oe, ch_an;
  logic [2:0] avg;
  logic [3:0] div;
  logic [7:0] exp_reg [16];
  int         n_fail, samples_checked;

  // A released open-drain output (level high, enable low) floats up to its pull-up.
  // Every other undriven pin follows the outside level.
  assign pin_in = pin_out | (~pin_oe & ext);

  acr_config_regs uut (.CLOCK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .SW_RESET(sw_rst), .CHECK_ERROR(err), .FORCE_ALL_ANALOG(force_an), .AVG_DEPTH(avg),
    .TRIG_AUTONOMOUS(trig), .OSC_LOW_POWER(osc), .SAMPLE_DIV(div), .SEQ_ENABLE(seq),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CH_ANALOG(ch_an));

  acr_host_model host (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd),
    .rdata(rdata), .rvalid(rvalid), .err(err));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      ADDR_AVG_CFG: return 8'h07;
      ADDR_MODE_CFG, ADDR_FUNC_CFG, ADDR_DIR_CFG, ADDR_DRIVE_CFG, ADDR_LEVEL_VAL: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : wmask

  function automatic logic forced();
    return force_an || (err && exp_reg[4][7]);
  endfunction : forced

  function automatic logic [7:0] dig_en();
    return forced() ? 8'h00 : exp_reg[5] & exp_reg[7];
  endfunction : dig_en

  function automatic logic [7:0] exp_oe();
    return dig_en() & (exp_reg[9] | ~exp_reg[11]);
  endfunction : exp_oe

  function automatic logic [7:0] exp_in();
    return (dig_en() & exp_reg[11]) | (~dig_en() & ext);
  endfunction : exp_in

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.wr_reg(a, d);
    exp_reg[a[3:0]] = (exp_reg[a[3:0]] & ~wmask(a)) | (d & wmask(a));
  endtask : wreg

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    logic       ok;
    host.rd_reg(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, (a == ADDR_INPUT_VAL) ? exp_in() : exp_reg[a[3:0]]);
  endtask : rd_chk

  task automatic check_outs();
    logic auto_q;
    auto_q = (exp_reg[4][6:5] == TRIG_AUTO);
    chk({5'h00, avg}, {5'h00, exp_reg[3][2:0]});
    chk({7'h00, trig}, {7'h00, auto_q});
    chk({7'h00, osc}, {7'h00, exp_reg[4][4]});
    chk({4'h0, div}, auto_q ? {4'h0, exp_reg[4][3:0]} : 8'h00);
    chk(pin_oe, exp_oe());
    chk(pin_out, dig_en() & exp_reg[11]);
    chk(ch_an, forced() ? 8'hFF : ~exp_reg[5]);
    chk({7'h00, seq}, {7'h00, !(err && exp_reg[4][7])});
  endtask : check_outs

  initial begin
    #(40 * 20000);
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    sw_rst = 1'b0;
    force_an = 1'b0;
    ext = 8'hA5;
    n_fail = 0;
    samples_checked = 0;
    foreach (exp_reg[i]) exp_reg[i] = REG_RESET;
    void'($urandom(23885));
    settle(10);
    rst_n = 1'b1;
    check_outs();
    for (int a = 0; a < 16; a++) rd_chk(8'(a));
    for (int c = 0; c < 4; c++) begin
      wreg(ADDR_MODE_CFG, {1'b0, 2'(c), c[0], 4'hF});
      settle(1);
      check_outs();
    end
    wreg(ADDR_AVG_CFG, 8'hFF);
    settle(1);
    check_outs();
    rd_chk(ADDR_AVG_CFG);
    for (int i = 0; i < 80; i++) begin
      wreg(8'($urandom_range(15)), 8'($urandom));
      ext = 8'($urandom);
      settle(2);
      check_outs();
      rd_chk(8'($urandom_range(15)));
    end
    wreg(ADDR_FUNC_CFG, 8'hFF);
    wreg(ADDR_DIR_CFG, 8'hF0);
    wreg(ADDR_DRIVE_CFG, 8'h3C);
    wreg(ADDR_LEVEL_VAL, 8'h96);
    for (int h = 0; h < 2; h++) begin
      wreg(ADDR_MODE_CFG, {h[0], 7'h21});
      host.set_err(1'b1);
      settle(1);
      chk({7'h00, seq}, {7'h00, !h[0]});
      settle(1);
      check_outs();
      host.set_err(1'b0);
      settle(2);
      check_outs();
    end
    force_an = 1'b1;
    settle(2);
    check_outs();
    force_an = 1'b0;
    sw_rst = 1'b1;
    foreach (exp_reg[i]) exp_reg[i] = REG_RESET;
    // The read strobe rises in the cycle right after the software reset pulse.
    fork
      rd_chk(ADDR_MODE_CFG);
      begin
        @(negedge clk);
        sw_rst = 1'b0;
      end
    join
    settle(2);
    check_outs();
    rd_chk(ADDR_MODE_CFG);
    wrap_up();
  end
endmodule : adc_mode_and_pin_config_regs_bench
